// file: hw/otl_timer_line.sv
// Output timers with shared duration base, plus line level readback.
// Assumes an Avalon-MM master on mclk, an exposure-active level from
// logic on mclk, and input pins that are asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
`include "otl_defs.svh"

module otl_timer_line
  import otl_pkg::*;
#(
  parameter int N_TIMERS = 4,
  parameter int N_IN = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic exposure_active,
  input wire logic [N_IN-1:0] in_line,
  output logic [N_TIMERS-1:0] out_line
);

  localparam int TB_W = 16;
  localparam int ABS_W = `OTL_RAW_W + TB_W;
  localparam int SEL_W = $clog2(N_TIMERS);
  localparam int DCNT_W = $clog2(ABS_W + 1);
  localparam logic [`OTL_PRE_W-1:0] US_LAST = `OTL_PRE_W'(`OTL_US_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Functions
  ////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into the present register image
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Effective time in microseconds from raw count and base
  function automatic logic [ABS_W-1:0] abs_of(
      input logic [`OTL_RAW_W-1:0] raw, input logic [TB_W-1:0] tb);
    return ABS_W'(raw) * ABS_W'(tb);
  endfunction : abs_of

  // Base never goes below one microsecond
  function automatic logic [TB_W-1:0] base_fix(input logic [TB_W-1:0] v);
    return (v < `OTL_BASE_MIN) ? `OTL_BASE_MIN : v;
  endfunction : base_fix

  // Raw duration limited to its legal span
  function automatic logic [`OTL_RAW_W-1:0] dur_fix(
      input logic [ABS_W-1:0] v);
    if (v < ABS_W'(`OTL_DUR_RAW_MIN)) begin
      return `OTL_DUR_RAW_MIN;
    end else if (v > ABS_W'(`OTL_RAW_MAX)) begin
      return `OTL_RAW_MAX;
    end
    return v[`OTL_RAW_W-1:0];
  endfunction : dur_fix

  // True on the last clock cycle of a phase of tb*target microseconds
  function automatic logic phase_end(input otl_tcnt_t c,
                                     input logic [TB_W-1:0] tb,
                                     input logic [`OTL_RAW_W-1:0] target);
    return (c.pre == US_LAST) && (c.base == tb - 16'h0001) &&
           (c.unit == target - 12'h001);
  endfunction : phase_end

  // Advance the microsecond, base and unit counters by one clock
  function automatic otl_tcnt_t cnt_step(input otl_tcnt_t c,
                                         input logic [TB_W-1:0] tb);
    otl_tcnt_t n;
    n = c;
    if (c.pre != US_LAST) begin
      n.pre = c.pre + `OTL_PRE_W'(1);
    end else begin
      n.pre = '0;
      if (c.base != tb - 16'h0001) begin
        n.base = c.base + 16'h0001;
      end else begin
        n.base = '0;
        n.unit = c.unit + 12'h001;
      end
    end
    return n;
  endfunction : cnt_step

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////
  logic [SEL_W-1:0] sel_q; // Timer selector
  logic [TB_W-1:0] dur_tb_q; // Shared duration base, microseconds
  logic [TB_W-1:0] dly_tb_q; // Shared delay base, microseconds
  otl_tcfg_t cfg_q [N_TIMERS]; // Per-timer raw settings
  logic [SEL_W-1:0] line_sel_q; // Output line selector
  logic [N_TIMERS-1:0] trig_en_q; // Timer arm bits
  logic ack_q; // Bus answer pending this cycle
  logic [31:0] readdata_q; // Registered read data
  logic [ABS_W-1:0] div_num_q; // Dividend, shifted out MSB first
  logic [ABS_W-1:0] div_rem_q; // Partial remainder
  logic [ABS_W-1:0] div_quo_q; // Quotient being built
  logic [DCNT_W-1:0] div_cnt_q; // Steps left
  logic div_busy_q; // Division running
  logic div_done_q; // Quotient ready for the pending write
  logic [N_IN-1:0] in_meta_q; // First synchroniser stage
  logic [N_IN-1:0] in_sync_q; // Line levels on mclk
  logic expo_q; // Exposure level, last cycle
  otl_state_t st_q [N_TIMERS]; // Timer phase
  otl_tcnt_t cnt_q [N_TIMERS]; // Timer counters
  logic [N_TIMERS-1:0] out_q; // Timer output levels
  logic req; // A bus request is present
  logic abs_wr; // Request is an absolute duration write
  logic commit; // Edge at which the request completes
  logic expo_rise; // Start of exposure
  logic [ABS_W-1:0] rem_sh; // Remainder after shifting in next bit
  logic [31:0] rd_val; // Read multiplexer
  logic [31:0] line_all; // All-lines status word
  logic [31:0] wr_word; // Write data merged into the addressed register

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake
  ////////////////////////////////////////////////////////////////////////
  assign req = read | write;
  assign abs_wr = write && (address == `OTL_OFS_DUR_ABS);
  assign commit = req && ack_q;
  // Held off until the registered answer or the quotient is ready
  assign waitrequest = req && !ack_q;
  assign readdata = readdata_q;

  // Answer one cycle after the request, later while dividing
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else if (ack_q) begin
      ack_q <= 1'b0;
    end else if (req && (!abs_wr || div_done_q)) begin
      ack_q <= 1'b1;
    end
  end

  // Read data are captured once, while the request stands still
  always_ff @(posedge mclk) begin
    if (reset) begin
      readdata_q <= 32'h00000000;
    end else if (read && !ack_q) begin
      readdata_q <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Absolute to raw conversion
  ////////////////////////////////////////////////////////////////////////
  // Restoring division: a combinational divide by a 16-bit variable would
  // set the clock rate; the bus simply waits ABS_W + 2 cycles instead.
  assign rem_sh = {div_rem_q[ABS_W-2:0], div_num_q[ABS_W-1]};

  always_ff @(posedge mclk) begin
    if (reset) begin
      div_busy_q <= 1'b0;
      div_done_q <= 1'b0;
      div_cnt_q <= '0;
      div_num_q <= '0;
      div_rem_q <= '0;
      div_quo_q <= '0;
    end else if (abs_wr && !ack_q && !div_busy_q && !div_done_q) begin
      div_busy_q <= 1'b1;
      div_cnt_q <= DCNT_W'(ABS_W);
      div_num_q <= ABS_W'(be_merge(32'h00000000, writedata,
                                   byteenable));
      div_rem_q <= '0;
      div_quo_q <= '0;
    end else if (div_busy_q) begin
      div_num_q <= {div_num_q[ABS_W-2:0], 1'b0};
      if (rem_sh >= ABS_W'(dur_tb_q)) begin
        div_rem_q <= rem_sh - ABS_W'(dur_tb_q);
        div_quo_q <= {div_quo_q[ABS_W-2:0], 1'b1};
      end else begin
        div_rem_q <= rem_sh;
        div_quo_q <= {div_quo_q[ABS_W-2:0], 1'b0};
      end
      div_cnt_q <= div_cnt_q - DCNT_W'(1);
      if (div_cnt_q == DCNT_W'(1)) begin
        div_busy_q <= 1'b0;
        div_done_q <= 1'b1;
      end
    end else if (commit) begin
      div_done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  ////////////////////////////////////////////////////////////////////////
  // Byte lanes merge into the present image that the read mux shows
  assign wr_word = be_merge(rd_val, writedata, byteenable);

  // Selectors, shared bases and arm bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_q <= '0;
      line_sel_q <= '0;
      dur_tb_q <= `OTL_BASE_RST;
      dly_tb_q <= `OTL_BASE_RST;
      trig_en_q <= '0;
    end else if (commit && write) begin
      unique case (address)
        `OTL_OFS_TIMER_SEL: sel_q <= wr_word[SEL_W-1:0];
        `OTL_OFS_LINE_SEL: line_sel_q <= wr_word[SEL_W-1:0];
        // One register serves every timer, in 1 us steps
        `OTL_OFS_DUR_BASE: dur_tb_q <= base_fix(wr_word[TB_W-1:0]);
        `OTL_OFS_DLY_BASE: dly_tb_q <= base_fix(wr_word[TB_W-1:0]);
        `OTL_OFS_TRIG_EN: trig_en_q <= wr_word[N_TIMERS-1:0];
        default: begin
          // Other offsets hold no control state here
        end
      endcase
    end
  end

  // Per-timer raw counts; the absolute value is never stored, so the
  // readback always follows the raw count and the present base
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < N_TIMERS; i++) begin
        cfg_q[i].dur_raw <= `OTL_DUR_RAW_RST;
        cfg_q[i].dly_raw <= `OTL_DLY_RAW_RST;
      end
    end else if (commit && write) begin
      if (address == `OTL_OFS_DUR_RAW) begin
        cfg_q[sel_q].dur_raw <= dur_fix(
            ABS_W'(wr_word[`OTL_RAW_W-1:0]));
      end else if (address == `OTL_OFS_DUR_ABS) begin
        // Off-multiple values truncate; software keeps to multiples
        cfg_q[sel_q].dur_raw <= dur_fix(div_quo_q);
      end else if (address == `OTL_OFS_DLY_RAW) begin
        cfg_q[sel_q].dly_raw <= wr_word[`OTL_RAW_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line levels
  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for the asynchronous input pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_meta_q <= '0;
      in_sync_q <= '0;
    end else begin
      in_meta_q <= in_line;
      in_sync_q <= in_meta_q;
    end
  end

  // Fixed positions: outputs from bit 0, inputs from bit 8
  always_comb begin
    line_all = 32'h00000000;
    line_all[`OTL_ALL_OUT_LSB +: N_TIMERS] = out_q;
    line_all[`OTL_ALL_IN_LSB +: N_IN] = in_sync_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  ////////////////////////////////////////////////////////////////////////
  // Unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h00000000;
    unique case (address)
      `OTL_OFS_TIMER_SEL: rd_val = 32'(sel_q);
      `OTL_OFS_DUR_BASE: rd_val = 32'(dur_tb_q);
      `OTL_OFS_DUR_RAW: rd_val = 32'(cfg_q[sel_q].dur_raw);
      `OTL_OFS_DUR_ABS: begin
        rd_val = 32'(abs_of(cfg_q[sel_q].dur_raw, dur_tb_q));
      end
      `OTL_OFS_DLY_BASE: rd_val = 32'(dly_tb_q);
      `OTL_OFS_DLY_RAW: rd_val = 32'(cfg_q[sel_q].dly_raw);
      `OTL_OFS_LINE_SEL: rd_val = 32'(line_sel_q);
      `OTL_OFS_LINE_STAT: rd_val = 32'(out_q[line_sel_q]);
      `OTL_OFS_LINE_ALL: rd_val = line_all;
      `OTL_OFS_TRIG_EN: rd_val = 32'(trig_en_q);
      default: rd_val = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers
  ////////////////////////////////////////////////////////////////////////
  // Exposure comes from logic on mclk, so only an edge detector is needed
  always_ff @(posedge mclk) begin
    if (reset) begin
      expo_q <= 1'b0;
    end else begin
      expo_q <= exposure_active;
    end
  end

  assign expo_rise = exposure_active && !expo_q;

  // Each timer keeps its own microsecond prescaler so that a pulse is
  // exactly raw*base microseconds, not short by up to one microsecond.
  // A trigger while a timer runs is ignored, and settings are read live.
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < N_TIMERS; i++) begin
        st_q[i] <= OTL_IDLE;
        cnt_q[i] <= '0;
        out_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < N_TIMERS; i++) begin
        unique case (st_q[i])
          OTL_IDLE: begin
            cnt_q[i] <= '0;
            if (expo_rise && trig_en_q[i]) begin
              if (cfg_q[i].dly_raw == `OTL_DLY_RAW_RST) begin
                st_q[i] <= OTL_PULSE;
                out_q[i] <= 1'b1;
              end else begin
                st_q[i] <= OTL_DELAY;
              end
            end
          end
          OTL_DELAY: begin
            if (phase_end(cnt_q[i], dly_tb_q, cfg_q[i].dly_raw)) begin
              st_q[i] <= OTL_PULSE;
              out_q[i] <= 1'b1;
              cnt_q[i] <= '0;
            end else begin
              cnt_q[i] <= cnt_step(cnt_q[i], dly_tb_q);
            end
          end
          OTL_PULSE: begin
            if (phase_end(cnt_q[i], dur_tb_q, cfg_q[i].dur_raw)) begin
              st_q[i] <= OTL_IDLE;
              out_q[i] <= 1'b0;
              cnt_q[i] <= '0;
            end else begin
              cnt_q[i] <= cnt_step(cnt_q[i], dur_tb_q);
            end
          end
          default: begin
            st_q[i] <= OTL_IDLE;
            out_q[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Timer i drives output line i and no other
  assign out_line = out_q;

endmodule : otl_timer_line

`default_nettype wire

// file: inc/otl_defs.svh
// Constants of the output timer and line status block: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and the design module.
`ifndef OTL_DEFS_SVH
`define OTL_DEFS_SVH

// Word-aligned byte offsets of the registers
`define OTL_OFS_TIMER_SEL 6'h00
`define OTL_OFS_DUR_BASE 6'h04
`define OTL_OFS_DUR_RAW 6'h08
`define OTL_OFS_DUR_ABS 6'h0C
`define OTL_OFS_DLY_BASE 6'h10
`define OTL_OFS_DLY_RAW 6'h14
`define OTL_OFS_LINE_SEL 6'h18
`define OTL_OFS_LINE_STAT 6'h1C
`define OTL_OFS_LINE_ALL 6'h20
`define OTL_OFS_TRIG_EN 6'h24

// Field limits and reset values
`define OTL_RAW_W 12
`define OTL_DUR_RAW_MIN 12'h001
`define OTL_RAW_MAX 12'hFFF
`define OTL_DUR_RAW_RST 12'h001
`define OTL_DLY_RAW_RST 12'h000
`define OTL_BASE_RST 16'h0001
`define OTL_BASE_MIN 16'h0001

// Bit positions inside the all-lines status word
`define OTL_ALL_OUT_LSB 0
`define OTL_ALL_IN_LSB 8

// Timing: one microsecond time unit at the system clock rate
`define OTL_US_NS 1000
`define OTL_CLK_NS 8
`define OTL_US_CYC (`OTL_US_NS / `OTL_CLK_NS)
`define OTL_PRE_W 7

`endif

// file: inc/otl_pkg.sv
// Types shared by the output timer and line status block.
// Assumes otl_defs.svh is on the include path.
`include "otl_defs.svh"

package otl_pkg;

  // Timer sequencing, one-hot
  typedef enum logic [2:0] {
    OTL_IDLE = 3'b001,
    OTL_DELAY = 3'b010,
    OTL_PULSE = 3'b100
  } otl_state_t;

  // Per-timer settings as software leaves them
  typedef struct packed {
    logic [`OTL_RAW_W-1:0] dly_raw;
    logic [`OTL_RAW_W-1:0] dur_raw;
  } otl_tcfg_t;

  // Per-timer running counters
  typedef struct packed {
    logic [`OTL_PRE_W-1:0] pre;
    logic [15:0] base;
    logic [`OTL_RAW_W-1:0] unit;
  } otl_tcnt_t;

endpackage : otl_pkg

// file: sim/otl_chk.sv
// Checker for the output timer and line status block.
// Assumes it is bound to otl_timer_line and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "otl_defs.svh"

module otl_chk #(
  parameter int N_TIMERS = 4,
  parameter int N_IN = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic exposure_active,
  input wire logic [N_IN-1:0] in_line,
  input wire logic [N_TIMERS-1:0] out_line
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [7:0] wait_q; // Wait cycles of the request in flight
  logic [31:0] hi_q; // High cycles of output line 1
  logic [15:0] base_q; // Shadow of the duration base
  logic [1:0] lsel_q; // Shadow of the line selector
  logic [N_TIMERS-1:0] arm_q; // Shadow of the arm bits
  logic exp_q; // Exposure seen since reset
  wire logic done = (read | write) & ~waitrequest;

  ////////////////////////////////////////////////////////////////////
  // Count wait cycles; cleared at completion so back to back works
  always_ff @(posedge mclk) begin
    if (reset || !(read || write) || !waitrequest) wait_q <= 8'h00;
    else wait_q <= wait_q + 8'h01;
  end

  // Length of the running pulse on line 1
  always_ff @(posedge mclk) begin
    if (reset || !out_line[0]) hi_q <= 32'h0;
    else hi_q <= hi_q + 32'h1;
  end

  // Shadows follow whole-word writes only; partial lanes are not modelled
  always_ff @(posedge mclk) begin
    if (reset) begin
      base_q <= `OTL_BASE_RST;
      lsel_q <= 2'h0;
      arm_q <= '0;
    end else if (done && write && byteenable == 4'hF) begin
      if (address == `OTL_OFS_DUR_BASE) begin
        base_q <= (writedata[15:0] == 16'h0) ? 16'h1 : writedata[15:0];
      end
      if (address == `OTL_OFS_LINE_SEL) lsel_q <= writedata[1:0];
      if (address == `OTL_OFS_TRIG_EN) arm_q <= writedata[N_TIMERS-1:0];
    end
  end

  // Exposure must have been active before any pulse on line 1
  always_ff @(posedge mclk) begin
    if (reset) exp_q <= 1'b0;
    else if (exposure_active) exp_q <= 1'b1;
  end

  a_read_one_wait: assert property (done && read |-> wait_q == 8'h01)
    else $error("read answered after wrong number of waits");
  a_abs_wait_30: assert property (
    done && write && address == `OTL_OFS_DUR_ABS |-> wait_q == 8'h1E)
    else $error("duration conversion wait not 30 cycles");
  a_base_read: assert property (
    done && read && address == `OTL_OFS_DUR_BASE
    |-> readdata == {16'h0000, base_q})
    else $error("duration base read wrong");
  a_stat_level: assert property (
    done && read && address == `OTL_OFS_LINE_STAT
    |-> readdata == {31'h0, $past(out_line[lsel_q])})
    else $error("line status does not match selected line");
  a_all_unused: assert property (
    done && read && address == `OTL_OFS_LINE_ALL
    |-> readdata[31:10] == 22'h0 && readdata[7:4] == 4'h0)
    else $error("unused status bits not zero");
  a_all_outputs: assert property (
    done && read && address == `OTL_OFS_LINE_ALL
    |-> readdata[3:0] == $past(out_line))
    else $error("status bits differ from output lines");
  a_all_inputs: assert property (
    done && read && address == `OTL_OFS_LINE_ALL && $stable(in_line)
    |-> readdata[9:8] == $past(in_line, 3))
    else $error("status bits differ from input lines");
  a_pulse_units: assert property (
    $fell(out_line[0]) && !$past(reset)
    |-> hi_q != 32'h0 && hi_q % 125 == 0)
    else $error("pulse not a whole number of microseconds");
  a_exp_trigger: assert property ($rose(out_line[0]) |-> exp_q)
    else $error("pulse without exposure");
  a_armed_only: assert property (
    (out_line & ~$past(out_line) & ~arm_q) == '0)
    else $error("unarmed output line rose");

  c_abs_write: cover property (done && write
    && address == `OTL_OFS_DUR_ABS);
  c_pulse_end: cover property ($fell(out_line[0]));
  c_all_read: cover property (done && read
    && address == `OTL_OFS_LINE_ALL);
endmodule : otl_chk

bind otl_timer_line otl_chk #(
  .N_TIMERS(N_TIMERS),
  .N_IN(N_IN)
) chk_u (
  .mclk(mclk),
  .reset(reset),
  .address(address),
  .read(read),
  .write(write),
  .byteenable(byteenable),
  .writedata(writedata),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .exposure_active(exposure_active),
  .in_line(in_line),
  .out_line(out_line)
);
`default_nettype wire

// file: sim/otl_partner.sv
// Equipment on the camera lines: drives the inputs, counts output rises, times line 1 pulses.
// Assumes the bench sets the input levels on lvl.
`timescale 1ns/1ns
`default_nettype none

module otl_partner (
  input wire logic mclk,
  input wire logic [3:0] out_line,
  input wire logic [1:0] lvl,
  output logic [1:0] in_line = 2'h0,
  output logic [31:0] width_last = 32'h0,
  output logic [7:0] n_pulse = 8'h0,
  output logic [7:0] n_done = 8'h0
);
  logic [31:0] run_q = 32'h0; // High cycles of line 1 so far
  logic [3:0] prev_q = 4'h0; // Line levels one cycle back

  ////////////////////////////////////////////////////////////////////
  // Rises on any line are counted, so a stray line shows up at once
  always @(posedge mclk) begin
    in_line <= lvl;
    prev_q <= out_line;
    n_pulse <= n_pulse + 8'($countones(out_line & ~prev_q));
    if (out_line[0]) begin
      run_q <= run_q + 32'h1;
    end else if (prev_q[0]) begin
      width_last <= run_q;
      run_q <= 32'h0;
      n_done <= n_done + 8'h1;
    end
  end
endmodule : otl_partner
`default_nettype wire

// file: sim/otl_timer_line_tb_top.sv
// Self-checking bench: bus tasks and one task per scenario.
// Assumes the partner on the lines and the checker bound to the design.
`timescale 1ns/1ns
`default_nettype none
`include "otl_defs.svh"

module otl_timer_line_tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic exposure_active = 1'b0;
  logic [1:0] lvl = 2'h0; // Input line levels the partner drives
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] out_line;
  logic [1:0] in_line;
  logic [31:0] width_last;
  logic [7:0] n_pulse;
  logic [7:0] n_done;
  int err_total = 0;
  int n_tests = 0;

  otl_timer_line dut_u (.mclk(mclk), .reset(reset), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .exposure_active(exposure_active),
    .in_line(in_line), .out_line(out_line));
  otl_partner far_u (.mclk(mclk), .out_line(out_line), .lvl(lvl),
    .in_line(in_line), .width_last(width_last), .n_pulse(n_pulse),
    .n_done(n_done));

  // 125 MHz clock
  initial forever #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One bus transfer, entered just after an edge; the request stands until
  // the edge that samples waitrequest low, then one idle edge follows
  task automatic bus(input logic is_wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    logic w;
    k = 0;
    address <= a;
    read <= ~is_wr;
    write <= is_wr;
    writedata <= d;
    do begin
      @(posedge mclk);
      w = waitrequest;
      q = readdata;
      k++;
    end while (w !== 1'b0 && k < 200);
    read <= 1'b0;
    write <= 1'b0;
    if (w !== 1'b0) begin
      err_total++;
      summarize();
    end
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask : rdc

  // Bounded wait for the partner to finish timing a pulse
  task automatic wait_done(input logic [7:0] n);
    int k;
    k = 0;
    while (n_done !== n && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    if (n_done !== n) begin
      err_total++;
      summarize();
    end
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    rdc(`OTL_OFS_DUR_BASE, 32'h1);
    rdc(`OTL_OFS_DUR_RAW, 32'h1);
    rdc(`OTL_OFS_DUR_ABS, 32'h1);
    wr(6'h3C, 32'hFFFFFFFF);
    rdc(6'h3C, 32'h0);
    wr(`OTL_OFS_DUR_BASE, 32'h0);
    rdc(`OTL_OFS_DUR_BASE, 32'h1);
  endtask : t_reset_vals

  // One base for all four timers, absolute follows raw
  task automatic t_shared_base();
    wr(`OTL_OFS_DUR_BASE, 32'h32);
    for (int i = 0; i < 4; i++) begin
      wr(`OTL_OFS_TIMER_SEL, 32'(i));
      wr(`OTL_OFS_DUR_RAW, 32'(i + 1));
    end
    for (int i = 0; i < 4; i++) begin
      wr(`OTL_OFS_TIMER_SEL, 32'(i));
      rdc(`OTL_OFS_DUR_ABS, 32'((i + 1) * 50));
    end
    wr(`OTL_OFS_DUR_BASE, 32'h3);
    wr(`OTL_OFS_TIMER_SEL, 32'h2);
    rdc(`OTL_OFS_DUR_ABS, 32'h9);
    wr(`OTL_OFS_DUR_RAW, 32'h0);
    rdc(`OTL_OFS_DUR_RAW, 32'h1);
    wr(`OTL_OFS_DUR_RAW, 32'hFFF);
    rdc(`OTL_OFS_DUR_ABS, 32'h2FFD);
  endtask : t_shared_base

  // Absolute writes at multiples of a 50 us base, up to the top raw
  task automatic t_abs_write();
    logic [31:0] av [3];
    logic [31:0] rv [3];
    av = '{32'h96, 32'h32, 32'h31FCE};
    rv = '{32'h3, 32'h1, 32'hFFF};
    wr(`OTL_OFS_DUR_BASE, 32'h32);
    wr(`OTL_OFS_TIMER_SEL, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(`OTL_OFS_DUR_ABS, av[i]);
      rdc(`OTL_OFS_DUR_RAW, rv[i]);
      rdc(`OTL_OFS_DUR_ABS, av[i]);
    end
    wr(`OTL_OFS_TIMER_SEL, 32'h0);
    rdc(`OTL_OFS_DUR_ABS, 32'h32);
  endtask : t_abs_write

  // Exposure pulses on timer 1 only, raw then absolute duration
  task automatic t_pulse();
    wr(`OTL_OFS_DUR_BASE, 32'h1);
    wr(`OTL_OFS_DUR_RAW, 32'h2);
    wr(`OTL_OFS_LINE_SEL, 32'h0);
    wr(`OTL_OFS_TRIG_EN, 32'h1);
    exposure_active <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(`OTL_OFS_LINE_STAT, 32'h1);
    wr(`OTL_OFS_LINE_SEL, 32'h1);
    rdc(`OTL_OFS_LINE_STAT, 32'h0);
    rdc(`OTL_OFS_LINE_ALL, 32'h1);
    wait_done(8'h1);
    cmp(width_last, 32'hFA);
    // Exposure stays high: no second trigger may follow
    repeat (300) @(posedge mclk);
    cmp({24'h0, n_pulse}, 32'h1);
    exposure_active <= 1'b0;
    wr(`OTL_OFS_DUR_ABS, 32'h3);
    rdc(`OTL_OFS_DUR_RAW, 32'h3);
    exposure_active <= 1'b1;
    wait_done(8'h2);
    cmp(width_last, 32'h177);
    cmp({24'h0, n_pulse}, 32'h2);
  endtask : t_pulse

  // Delayed pulse on timer 3 alone: 250 cycles low, then 125 high
  task automatic t_delay();
    exposure_active <= 1'b0;
    wr(`OTL_OFS_TIMER_SEL, 32'h2);
    wr(`OTL_OFS_DUR_RAW, 32'h1);
    wr(`OTL_OFS_DLY_BASE, 32'h2);
    wr(`OTL_OFS_DLY_RAW, 32'h1);
    wr(`OTL_OFS_TRIG_EN, 32'h4);
    exposure_active <= 1'b1;
    repeat (200) @(posedge mclk);
    rdc(`OTL_OFS_LINE_ALL, 32'h0);
    repeat (100) @(posedge mclk);
    rdc(`OTL_OFS_LINE_ALL, 32'h4);
    repeat (150) @(posedge mclk);
    cmp({24'h0, n_pulse}, 32'h3);
  endtask : t_delay

  // Input levels in the all-lines word; writes there are ignored
  task automatic t_lines();
    lvl <= 2'h2;
    repeat (4) @(posedge mclk);
    rdc(`OTL_OFS_LINE_ALL, 32'h200);
    wr(`OTL_OFS_LINE_ALL, 32'hFFFFFFFF);
    rdc(`OTL_OFS_LINE_ALL, 32'h200);
    lvl <= 2'h1;
    repeat (4) @(posedge mclk);
    rdc(`OTL_OFS_LINE_ALL, 32'h100);
  endtask : t_lines

  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset_vals();
    t_shared_base();
    t_abs_write();
    t_pulse();
    t_delay();
    t_lines();
    summarize();
  end
endmodule : otl_timer_line_tb_top
`default_nettype wire
